// File: nested_priority_interrupt_controller_bench.sv
// self-checking bench for the nested priority interrupt controller
`timescale 1ns/1ps
`default_nettype none
module nested_priority_interrupt_controller_bench;
  import npic_pkg::*;
  logic          clk = 1'b0;
  logic          resetn = 1'b0;
  npic_wb_req_t  req = '0;
  npic_wb_rsp_t  rsp;
  npic_service_t svc;
  logic [13:0]   irq = '0;
  logic          stall = 1'b0;
  logic          insn_done;
  logic          wake;
  logic          halted;
  logic [7:0]    pop_flags;
  logic [7:0]    flags;
  logic [7:0]    rd;
  int            miscompares = 0;
  int            n_compared = 0;
  // row: address, write data, expected read back
  logic [19:0]   rows [7];
  logic [4:0]    cmds [3];

  always #10 clk = ~clk;

  npic_top i_npic_top (.clk(clk), .resetn(resetn), .wb_req(req), .irq_req(irq),
    .insn_done(insn_done), .pop_flags(pop_flags), .wb_rsp(rsp), .service(svc),
    .wake(wake), .halted(halted), .flags(flags));
  npic_core_model i_npic_core_model (.clk(clk), .stall(stall), .wb_req(req),
    .wb_rsp(rsp), .service(svc), .flags(flags), .insn_done(insn_done),
    .pop_flags(pop_flags));

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic bail(input string msg);
    miscompares++;
    $display("mismatch at %0t: %s timed out", $time, msg);
    test_done();
  endtask

  // one classic cycle, released only after ack is seen
  task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] dat);
    int n;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, dat: dat};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    if (n >= 20) bail("bus ack");
    rd = rsp.dat;
    req <= '0;
    @(posedge clk);
  endtask

  task automatic take(input logic fx, input logic [15:0] vec, input string msg);
    int n;
    n = 0;
    // take stands one cycle and may already be up when a bus call returns
    while (svc.take !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) bail(msg);
    chk(svc.vector, vec, msg);
    chk(16'(svc.fixed), 16'(fx), msg);
  endtask

  task automatic quiet(input int cyc, input string msg);
    int hits;
    hits = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (svc.take !== 1'b0) hits++;
    end
    chk(16'(hits), 16'h0000, msg);
  endtask

  task automatic level(input logic [1:0] exp, input string msg);
    wb(1'b0, ADDR_FLAGS, 8'h00);
    chk(16'({rd[FLAG_HI_POS], rd[FLAG_LO_POS]}), 16'(exp), msg);
    chk(16'(flags), 16'(rd), "flags port");
  endtask

  task automatic pulse(input logic [13:0] v);
    irq <= v;
    @(posedge clk);
    irq <= '0;
  endtask

  task automatic endt(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    rows = '{20'h1CFCF, 20'h16444, 20'h2AAFF, 20'h31B1F,
             20'h400F0, 20'h95500, 20'hF5A00};
    cmds = '{{CMD_ENABLE, PRIO_L0}, {CMD_DISABLE, PRIO_L3}, {CMD_WAIT, PRIO_L0}};
    repeat (20) @(posedge clk);
    chk(16'(flags), 16'(FLAGS_RST), "flags in reset");
    resetn <= 1'b1;
    take(1'b1, VEC_RESET, "reset service");
    level(PRIO_L3, "level after reset");
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, ADDR_VPRIO0 + 4'(i), 8'h00);
      chk(16'(rd), 16'(VPRIO_RST), "priority reset");
    end
    endt("reset");
    foreach (rows[i]) begin
      wb(1'b1, rows[i][19:16], rows[i][15:8]);
      wb(1'b0, rows[i][19:16], 8'h00);
      chk(16'(rd), 16'(rows[i][7:0]), "read back");
    end
    endt("registers");
    foreach (cmds[i]) begin
      wb(1'b1, ADDR_CMD, {5'h00, cmds[i][4:2]});
      level(cmds[i][1:0], "command level");
    end
    endt("commands");
    // routines below leave the level alone until return
    wb(1'b1, ADDR_ENABLE_LO, 8'hFF);
    wb(1'b1, ADDR_ENABLE_HI, 8'h3F);
    // fields: 1 and 3 at level 1, 2 at level 2
    stall <= 1'b1;
    pulse(14'h000E);
    repeat (4) @(posedge clk);
    stall <= 1'b0;
    take(1'b0, 16'hFFF6, "highest level first");
    level(PRIO_L2, "entry level");
    quiet(10, "lower level held");
    wb(1'b1, ADDR_CMD, {5'h00, CMD_RETURN});
    take(1'b0, 16'hFFF8, "tie to hardware order");
    wb(1'b1, ADDR_CMD, {5'h00, CMD_RETURN});
    take(1'b0, 16'hFFF4, "second tie");
    wb(1'b1, ADDR_CMD, {5'h00, CMD_RETURN});
    level(PRIO_L0, "level restored");
    endt("nesting");
    wb(1'b1, ADDR_CMD, {5'h00, CMD_HALT});
    chk(16'(halted), 16'h0001, "halt entered");
    level(PRIO_L0, "halt level");
    pulse(14'h0200);
    quiet(12, "serial source in halt");
    chk(16'(wake), 16'h0000, "no wake");
    pulse(14'h0100);
    take(1'b0, 16'hFFEA, "wake source");
    level(PRIO_L3, "wake entry level");
    wb(1'b1, ADDR_CMD, {5'h00, CMD_RETURN});
    take(1'b0, 16'hFFE8, "latched after halt");
    wb(1'b1, ADDR_CMD, {5'h00, CMD_RETURN});
    endt("halt");
    wb(1'b1, ADDR_CMD, {5'h00, CMD_DISABLE});
    pulse(14'h0001);
    take(1'b1, VEC_SRC0, "pin at level 3");
    level(PRIO_L3, "pin level");
    wb(1'b1, ADDR_CMD, {5'h00, CMD_TRAP});
    take(1'b1, VEC_TRAP, "trap");
    level(PRIO_L3, "trap level");
    endt("fixed sources");
    test_done();
  end
endmodule
`default_nettype wire

// File: npic_core_model.sv
// cpu core model: instruction boundary strobe and flags stack
`timescale 1ns/1ps
`default_nettype none
module npic_core_model (
  input  wire logic                    clk,
  input  wire logic                    stall,
  input  wire npic_pkg::npic_wb_req_t  wb_req,
  input  wire npic_pkg::npic_wb_rsp_t  wb_rsp,
  input  wire npic_pkg::npic_service_t service,
  input  wire logic [7:0]              flags,
  output logic                         insn_done,
  output logic [7:0]                   pop_flags
);
  import npic_pkg::*;
  logic [7:0] stk [0:15];
  logic [3:0] sp = 4'h0;
  // a stalled core models long instructions
  assign insn_done = !stall;
  assign pop_flags = stk[sp - 4'h1];
  always @(posedge clk) begin
    if (service.take === 1'b1) begin
      stk[sp] <= flags;
      sp <= sp + 4'h1;
    end
    // return pops after the request was taken
    if (wb_rsp.ack && wb_req.we && wb_req.adr == ADDR_CMD
        && wb_req.dat[2:0] == CMD_RETURN && sp != 4'h0) begin
      sp <= sp - 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: npic_field.sv
// module: one two-bit vector priority field with level 0 write filter and rank
`timescale 1ns/1ps
`default_nettype none
module npic_field (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr,
  input  wire logic [1:0] wdata,
  output logic      [1:0] code,
  output logic      [1:0] rank
);
  import npic_pkg::*;
  // [RULE8] level 0 code discarded
  // [RULE9] filter applies per field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code <= VPRIO_RST[1:0];
    end else if (wr && wdata != PRIO_L0) begin
      code <= wdata;
    end
  end
  // rank: 0 lowest .. 3 highest
  always_comb begin
    case (code)
      PRIO_L0: rank = 2'h0;
      PRIO_L1: rank = 2'h1;
      PRIO_L2: rank = 2'h2;
      default: rank = 2'h3;
    endcase
  end
endmodule
`default_nettype wire

// File: npic_pkg.sv
// package: register map, priority codes, vectors and carrier types of the interrupt controller
package npic_pkg;
  localparam int NUM_SRC = 14;
  localparam logic [1:0] PRIO_L0 = 2'h2;
  localparam logic [1:0] PRIO_L1 = 2'h1;
  localparam logic [1:0] PRIO_L2 = 2'h0;
  localparam logic [1:0] PRIO_L3 = 2'h3;
  localparam int FLAG_HI_POS = 5;
  localparam int FLAG_LO_POS = 3;
  localparam logic [7:0] FLAGS_RST = 8'hEA;
  localparam logic [7:0] VPRIO_RST = 8'hFF;
  localparam logic [7:0] VPRIO3_RO_MASK = 8'hF0;
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_VPRIO0 = 4'h1;
  localparam logic [3:0] ADDR_VPRIO3 = 4'h4;
  localparam logic [3:0] ADDR_ENABLE_LO = 4'h5;
  localparam logic [3:0] ADDR_ENABLE_HI = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_CMD = 4'h8;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_SRC0 = 16'hFFFA;
  localparam logic [13:0] WAKE_MASK = 14'h01FF;
  localparam int NMI_IDX = 0;
  // command register codes
  localparam logic [2:0] CMD_ENABLE = 3'h1;
  localparam logic [2:0] CMD_DISABLE = 3'h2;
  localparam logic [2:0] CMD_WAIT = 3'h3;
  localparam logic [2:0] CMD_HALT = 3'h4;
  localparam logic [2:0] CMD_TRAP = 3'h5;
  localparam logic [2:0] CMD_RETURN = 3'h6;
  localparam logic [2:0] CMD_FLAGS_POP = 3'h7;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [7:0]  dat;
  } npic_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [7:0]  dat;
  } npic_wb_rsp_t;

  typedef struct packed {
    logic        take;
    logic        fixed;
    logic [3:0]  src;
    logic [15:0] vector;
  } npic_service_t;
endpackage

// File: npic_top.sv
// module: nested priority interrupt controller with wishbone registers and service port
// Behaviour
// [RULE1] priority held in flags bits 5 and 3
// [RULE2] codes 10,01,00,11 give levels 0..3
// [RULE3] flags reset to 111x1010, level 3
// [RULE4] maskable entry loads vector priority
// [RULE5] four vector priority registers reset FFh
// [RULE6] fields follow vector order, fixed none
// [RULE7] last register upper nibble reads ones
// [RULE8] level 0 field write is ignored
// [RULE9] filter applies to each field separately
// [RULE10] pin field stored but never used
// [RULE11] fixed sources set level 3
// [RULE12] fixed sources serviced at level 3
// [RULE13] raised priority re-enters pending routine
// [RULE14] enable, wait, halt load level 0
// [RULE15] disable and trap load level 3
// [RULE16] return restores popped flags
// [RULE17] instructions change level in routine
// [RULE18] software avoids level instructions in routines
// [RULE19] fixed hardware order reset to serial
// [RULE20] two byte vectors descending by two
// [RULE21] only reset..CAN wake from halt
// [RULE22] serviced if enabled and higher level
// [RULE23] highest software, then hardware priority
// [RULE24] core stacks context before vector load
`timescale 1ns/1ps
`default_nettype none
module npic_top (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire npic_pkg::npic_wb_req_t wb_req,
  input  wire logic [13:0]            irq_req,
  input  wire logic                   insn_done,
  input  wire logic [7:0]             pop_flags,
  output npic_pkg::npic_wb_rsp_t      wb_rsp,
  output npic_pkg::npic_service_t     service,
  output logic                        wake,
  output logic                        halted,
  output logic [7:0]                  flags
);
  import npic_pkg::*;

  logic        rst_s1_ff;
  logic        rst_n;
  logic [13:0] irq_s1_ff;
  logic [13:0] irq_s2_ff;
  logic [7:0]  flags_ff;
  logic [13:0] enable_ff;
  logic [13:0] pend_ff;
  logic        trap_ff;
  logic        halt_ff;
  logic        reset_svc_ff;
  logic [1:0]  code   [NUM_SRC];
  logic [1:0]  rank   [NUM_SRC];
  logic [NUM_SRC-1:0] fwr;
  logic [1:0]  fdat   [NUM_SRC];
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  rd_data;
  logic [1:0]  cur_rank;
  logic [1:0]  cur_code;
  logic [2:0]  best_rank;
  logic [3:0]  best_idx;
  logic        best_ok;
  logic [2:0]  cand_rank;
  logic [13:0] cand_mask;
  logic        cmd_wr;
  logic [2:0]  cmd;
  logic        take_fix;
  logic        take_msk;

  // reset release through two flops; nothing but the second reads the first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_ff <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n     <= rst_s1_ff;
    end
  end

  // request lines come from pins and other clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_s1_ff <= '0;
      irq_s2_ff <= '0;
    end else begin
      irq_s1_ff <= irq_req;
      irq_s2_ff <= irq_s1_ff;
    end
  end

  // bus decode; one wait state per access
  assign wr_hit = wb_req.cyc && wb_req.stb && wb_req.we && !wb_rsp.ack;
  assign rd_hit = wb_req.cyc && wb_req.stb && !wb_req.we && !wb_rsp.ack;
  assign cmd_wr = wr_hit && wb_req.adr == ADDR_CMD;
  assign cmd    = wb_req.dat[2:0];

  // [RULE5] fourteen fields in four registers
  // [RULE6] field index follows vector order
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_fld
      assign fwr[gi]  = wr_hit && wb_req.adr == ADDR_VPRIO0 + 4'(gi / 4);
      assign fdat[gi] = wb_req.dat[2*(gi%4) +: 2];
      npic_field u_fld (
        .clk   (clk),
        .rst_n (rst_n),
        .wr    (fwr[gi]),
        .wdata (fdat[gi]),
        .code  (code[gi]),
        .rank  (rank[gi])
      );
    end
  endgenerate

  // [RULE1] priority bits sit at 5 and 3
  assign cur_code = {flags_ff[FLAG_HI_POS], flags_ff[FLAG_LO_POS]};
  // [RULE2] level ordering from code
  always_comb begin
    case (cur_code)
      PRIO_L0: cur_rank = 2'h0;
      PRIO_L1: cur_rank = 2'h1;
      PRIO_L2: cur_rank = 2'h2;
      default: cur_rank = 2'h3;
    endcase
  end

  // [RULE22] pending, enabled and above current level
  // [RULE10] pin field excluded from the maskable set
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      cand_mask[i] = pend_ff[i] && enable_ff[i] && (i != NMI_IDX) && (rank[i] > cur_rank)
                     && (!halt_ff || WAKE_MASK[i]);
    end
  end

  // [RULE23] highest software rank, ties to lowest index
  // [RULE19] lower index means higher hardware order
  always_comb begin
    best_rank = 3'h0;
    best_idx  = 4'h0;
    best_ok   = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      cand_rank = {1'b0, rank[i]} + 3'h1;
      if (cand_mask[i] && cand_rank >= best_rank) begin
        best_rank = cand_rank;
        best_idx  = 4'(i);
        best_ok   = 1'b1;
      end
    end
  end

  // [RULE12] fixed sources ignore current level
  // [RULE21] halt gates non waking sources
  assign take_fix = insn_done && (reset_svc_ff || (trap_ff && !halt_ff) || pend_ff[NMI_IDX]);
  assign take_msk = insn_done && !take_fix && best_ok;

  // synchronized request levels latch pending; service clears, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (irq_s2_ff[i]) begin
          pend_ff[i] <= 1'b1;
        end else if ((take_msk && best_idx == 4'(i)) ||
                     (take_fix && !reset_svc_ff && !(trap_ff && !halt_ff) && i == NMI_IDX)) begin
          pend_ff[i] <= 1'b0;
        end
      end
    end
  end

  // trap and reset vectors
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_ff      <= 1'b0;
      reset_svc_ff <= 1'b1;
    end else begin
      if (take_fix) begin
        reset_svc_ff <= 1'b0;
      end
      if (cmd_wr && cmd == CMD_TRAP) begin
        trap_ff <= 1'b1;
      end else if (take_fix && !reset_svc_ff && !halt_ff) begin
        trap_ff <= 1'b0;
      end
    end
  end

  // halt state; any waking service ends it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_ff <= 1'b0;
    end else if (take_fix || take_msk) begin
      halt_ff <= 1'b0;
    end else if (cmd_wr && cmd == CMD_HALT) begin
      halt_ff <= 1'b1;
    end
  end

  // [RULE3] flags reset value
  // [RULE11] fixed service forces level 3
  // [RULE4] maskable entry copies field
  // [RULE13] re-entry follows from field compare
  // [RULE14] enable, wait, halt give level 0
  // [RULE15] disable and trap give level 3
  // [RULE16] return reloads popped flags
  // [RULE17] flags pop also changes level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= FLAGS_RST;
    end else if (take_fix) begin
      flags_ff[FLAG_HI_POS] <= PRIO_L3[1];
      flags_ff[FLAG_LO_POS] <= PRIO_L3[0];
    end else if (take_msk) begin
      flags_ff[FLAG_HI_POS] <= code[best_idx][1];
      flags_ff[FLAG_LO_POS] <= code[best_idx][0];
    end else if (wr_hit && wb_req.adr == ADDR_FLAGS) begin
      flags_ff <= wb_req.dat;
    end else if (cmd_wr) begin
      case (cmd)
        CMD_ENABLE, CMD_WAIT, CMD_HALT: begin
          flags_ff[FLAG_HI_POS] <= PRIO_L0[1];
          flags_ff[FLAG_LO_POS] <= PRIO_L0[0];
        end
        CMD_DISABLE, CMD_TRAP: begin
          flags_ff[FLAG_HI_POS] <= PRIO_L3[1];
          flags_ff[FLAG_LO_POS] <= PRIO_L3[0];
        end
        CMD_RETURN, CMD_FLAGS_POP: begin
          flags_ff <= pop_flags;
        end
        default: begin
          flags_ff <= flags_ff;
        end
      endcase
    end
  end

  // source enables, 14 bits over two registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff <= '0;
    end else if (wr_hit && wb_req.adr == ADDR_ENABLE_LO) begin
      enable_ff[7:0] <= wb_req.dat;
    end else if (wr_hit && wb_req.adr == ADDR_ENABLE_HI) begin
      enable_ff[13:8] <= wb_req.dat[5:0];
    end
  end

  // [RULE7] upper nibble of last register reads ones
  always_comb begin
    case (wb_req.adr)
      ADDR_FLAGS:     rd_data = flags_ff;
      ADDR_VPRIO0:    rd_data = {code[3], code[2], code[1], code[0]};
      4'h2:           rd_data = {code[7], code[6], code[5], code[4]};
      4'h3:           rd_data = {code[11], code[10], code[9], code[8]};
      ADDR_VPRIO3:    rd_data = VPRIO3_RO_MASK | {4'h0, code[13], code[12]};
      ADDR_ENABLE_LO: rd_data = enable_ff[7:0];
      ADDR_ENABLE_HI: rd_data = {2'h0, enable_ff[13:8]};
      ADDR_STATUS:    rd_data = pend_ff[7:0];
      default:        rd_data = 8'h00;
    endcase
  end

  // unmapped addresses still ack, reading zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= wr_hit || rd_hit;
      wb_rsp.dat <= rd_hit ? rd_data : 8'h00;
    end
  end

  // [RULE20] vectors descend two bytes per source
  // [RULE24] core stacks context on take, then fetches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      service <= '0;
    end else begin
      service.take  <= take_fix || take_msk;
      service.fixed <= take_fix;
      if (take_fix) begin
        service.src    <= 4'h0;
        service.vector <= reset_svc_ff ? VEC_RESET : (trap_ff && !halt_ff) ? VEC_TRAP : VEC_SRC0;
      end else if (take_msk) begin
        service.src    <= best_idx;
        service.vector <= VEC_SRC0 - {11'h0, best_idx, 1'b0};
      end
    end
  end

  // [RULE21] wake from halt on waking sources
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake   <= 1'b0;
      halted <= 1'b0;
      flags  <= FLAGS_RST;
    end else begin
      wake   <= halt_ff && |(pend_ff & WAKE_MASK);
      halted <= halt_ff;
      flags  <= flags_ff;
    end
  end

  a_fix_level3: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
    take_fix |=> cur_code == PRIO_L3) else $error("fixed service did not set level 3");
  a_msk_load: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    take_msk |=> cur_code == $past(code[best_idx])) else $error("entry level not loaded");
  a_msk_above: assert property (@(posedge clk) disable iff (!rst_n) // [RULE22]
    take_msk |-> rank[best_idx] > cur_rank) else $error("serviced at or below level");
  a_svc_pulse: assert property (@(posedge clk) disable iff (!rst_n) // [RULE24]
    (take_fix || take_msk) |=> service.take) else $error("service not signalled");
  a_msk_vector: assert property (@(posedge clk) disable iff (!rst_n) // [RULE20]
    take_msk |=> service.vector == VEC_SRC0 - {11'h0, service.src, 1'b0}) else $error("bad vec");
  a_ro_nibble: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
    (rd_hit && wb_req.adr == ADDR_VPRIO3) |=> wb_rsp.dat[7:4] == 4'hF) else $error("ro nibble");
  a_no_level0: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    code[1] != PRIO_L0) else $error("level 0 stored in field");
  a_enable_l0: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
    (cmd_wr && cmd == CMD_ENABLE && !take_fix && !take_msk) |=> cur_code == PRIO_L0)
    else $error("enable did not load level 0");
  a_halt_wake: assert property (@(posedge clk) disable iff (!rst_n) // [RULE21]
    (halt_ff && take_msk) |-> WAKE_MASK[best_idx]) else $error("non waking source in halt");
  c_msk_take: cover property (@(posedge clk) disable iff (!rst_n) take_msk);
  c_nmi_take: cover property (@(posedge clk) disable iff (!rst_n) take_fix && pend_ff[NMI_IDX]);
  c_halt_exit: cover property (@(posedge clk) disable iff (!rst_n) halt_ff && take_msk);
endmodule
`default_nettype wire
